//--- axis_consts.svh
// Offsets, field positions, reset values and timing counts for the axis feedback block.
// Assumes a byte-addressed Avalon-MM slave with 32-bit data.
`ifndef AXIS_CONSTS_SVH
`define AXIS_CONSTS_SVH

// Per-channel register block, one block per axis
`define CH_SHIFT 6
`define REG_CTRL 6'h00
`define REG_MOT_LOW 6'h04
`define REG_MOT_RANGE 6'h08
`define REG_EXT_LOW 6'h0c
`define REG_EXT_RANGE 6'h10
`define REG_RPM 6'h14
`define REG_ACTUAL 6'h18
`define REG_AUX 6'h1c
`define REG_MAP 6'h20
`define REG_ERR 6'h24

// Global registers
`define REG_STATUS 9'h140
`define REG_MASK 9'h144

// Control fields
`define CTRL_EXT_SEL 0
`define CTRL_HOME_SRC 1
`define CTRL_HOME_GO 2

// Input map fields
`define MAP_A_LSB 0
`define MAP_Z_LSB 4
`define MAP_Z_EN 8

// Status field bases, one bit per axis
`define ST_OVER_POS 0
`define ST_OVER_NEG 8
`define ST_QUAD_ERR 16
`define ST_HOME_DONE 24

// Speed limit field bases and bounds in rpm
`define RPM_POS_LSB 0
`define RPM_NEG_LSB 16
`define RPM_MIN 16'h000a
`define RPM_MAX 16'h2710

// Error codes
`define ERR_OVER_POS 8'he5
`define ERR_OVER_NEG 8'he6
`define ERR_HOME_NO_MARKER 8'h30

// Reset values
`define RST_RANGE 32'h00000167
`define RST_MAP 32'h00000000

// Limiter response time
`define LIMIT_TIME_US 1000
`define CLK_MHZ 40
`define LIMIT_CYCLES (`LIMIT_TIME_US * `CLK_MHZ)

`endif

//--- axis_feedback_pkg.sv
// Types shared by the axis feedback block and its quadrature decoder.
// Assumes nothing beyond the constants header.
package axis_feedback_pkg;

	// One motor serial encoder sample for one axis
	typedef struct packed {
		logic valid;
		logic signed [15:0] delta;
		logic signed [15:0] speed;
	} motor_sample_type;

	// One decoded quadrature step
	typedef struct packed {
		logic step;
		logic up;
		logic err;
	} quad_step_type;

	// Home search progress
	typedef enum logic [1:0] {
		home_idle,
		home_wait_switch,
		home_wait_marker
	} home_state_type;

endpackage

//--- quad_decoder.sv
// Quadrature decoder for one A/B phase pair.
// Assumes a and b are already synchronised to mclk.
`timescale 1ns/100ps
`default_nettype none

module quad_decoder
	import axis_feedback_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic a,
	input wire logic b,
	output quad_step_type step_out
);

	logic prev_a; // Phase A one cycle ago
	logic prev_b; // Phase B one cycle ago

	// Remember last phase state
	always_ff @(posedge mclk) begin
		if (rst) begin
			prev_a <= 1'b0;
			prev_b <= 1'b0;
		end else begin
			prev_a <= a;
			prev_b <= b;
		end
	end

	// Decode one step per single-phase change
	always_ff @(posedge mclk) begin
		if (rst) begin
			step_out <= '0;
		end else begin
			step_out.step <= (a ^ prev_a) ^ (b ^ prev_b);
			step_out.up <= a ^ prev_b;
			step_out.err <= (a ^ prev_a) & (b ^ prev_b);
		end
	end

endmodule

`default_nettype wire

//--- axis_position_feedback_rollover.sv
// Position feedback with rollover, speed limiting and encoder mapping for several axes.
// Assumes motor samples come synchronous to mclk; encoder and home pins are asynchronous.
// What this block does
// - Positive motion past high limit wraps to low
// - Negative motion past low limit wraps to high
// - High limit equals low limit plus range
// - Non-source motor encoder always counts rotary
// - Positive overspeed raises E5h within 1 ms
// - Negative overspeed raises E6h within 1 ms
// - External selection closes loop on external count
// - Non-source external encoder counts rotary as auxiliary
// - Five channels, each A, B and marker
// - Axis n takes the phases its input map selects, inputs 0 and 1 after reset
// - One marker per channel, homing needs it
// - Phase A input implies next input phase B
// - Homing uses faceplate or terminal block switch
//
// The implementer's own choices: the Avalon-MM slave port and the register offsets.
`include "axis_consts.svh"
`timescale 1ns/100ps
`default_nettype none

module axis_position_feedback_rollover
	import axis_feedback_pkg::*;
#(
	parameter int NUM_CH = 5,
	parameter int NUM_IN = 12,
	parameter int LIMIT_CYCLES = `LIMIT_CYCLES
)(
	input wire logic mclk,
	input wire logic rst,
	input wire logic [8:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire motor_sample_type motor_sample [NUM_CH],
	input wire logic [NUM_IN-1:0] remote_terminal_block,
	input wire logic [NUM_CH-1:0] faceplate_inputs,
	input wire logic [NUM_CH-1:0] home_rtb,
	output logic signed [31:0] loop_position [NUM_CH],
	output logic [NUM_CH-1:0] fast_stop,
	output logic irq
);

	localparam int NUM_PINS = NUM_IN + 2 * NUM_CH; // All asynchronous pins

	logic [NUM_PINS-1:0] pin_raw; // Pins gathered
	logic [NUM_PINS-1:0] pin_s1; // First sync stage
	logic [NUM_PINS-1:0] pin_s2; // Second sync stage
	logic [NUM_PINS-1:0] pin_s3; // Third sync stage
	logic [NUM_PINS-1:0] pin_ok; // Agreed pin level
	logic [NUM_IN-1:0] enc_pin; // Encoder inputs, settled
	logic [NUM_CH-1:0] home_fp_pin; // Faceplate home switches, settled
	logic [NUM_CH-1:0] home_rtb_pin; // Terminal block home switches, settled

	logic [31:0] ctrl [NUM_CH]; // Control per axis
	logic signed [31:0] mot_low [NUM_CH]; // Motor encoder low limit
	logic signed [31:0] mot_range [NUM_CH]; // Motor encoder range
	logic signed [31:0] ext_low [NUM_CH]; // External encoder low limit
	logic signed [31:0] ext_range [NUM_CH]; // External encoder range
	logic [15:0] rpm_pos [NUM_CH]; // Positive speed limit
	logic [15:0] rpm_neg [NUM_CH]; // Negative speed limit
	logic [31:0] in_map [NUM_CH]; // Input assignment
	logic [7:0] err_code [NUM_CH]; // Last error code
	logic signed [31:0] mot_pos [NUM_CH]; // Motor encoder position
	logic signed [31:0] ext_pos [NUM_CH]; // External encoder position
	logic signed [15:0] speed_hold [NUM_CH]; // Latest motor speed
	home_state_type home_state [NUM_CH]; // Home search state
	quad_step_type qstep [NUM_CH]; // Decoded steps
	logic [NUM_CH-1:0] phase_a; // Selected phase A
	logic [NUM_CH-1:0] phase_b; // Selected phase B
	logic [NUM_CH-1:0] marker; // Selected marker
	logic [NUM_CH-1:0] marker_prev; // Marker one cycle ago
	logic [NUM_CH-1:0] home_sw; // Selected home switch
	logic [NUM_CH-1:0] home_go; // Home start pulse
	logic [NUM_CH-1:0] home_done; // Home finished pulse
	logic [NUM_CH-1:0] home_refused; // Home refused pulse
	logic [NUM_CH-1:0] over_pos; // Positive overspeed pulse
	logic [NUM_CH-1:0] over_neg; // Negative overspeed pulse
	logic [31:0] status; // Sticky events
	logic [31:0] mask; // Interrupt mask
	logic [31:0] ev_set; // Events this cycle
	logic [31:0] limit_cnt; // Limiter period counter
	logic limit_tick; // One pulse per limiter period
	logic bus_ack; // Access answered this cycle
	logic req; // Access pending
	logic [2:0] sel_ch; // Addressed channel
	logic [5:0] sel_reg; // Addressed channel register
	logic ch_hit; // Address falls in a channel block
	logic wr_ok; // Write accepted this cycle
	logic rd_ok; // Read accepted this cycle
	logic [31:0] next_rdata; // Read data being formed

	// Add a step and fold back into low .. low+range
	function automatic logic signed [31:0] wrap_add(input logic signed [31:0] pos,
			input logic signed [31:0] step, input logic signed [31:0] low,
			input logic signed [31:0] range);
		logic signed [31:0] high;
		logic signed [31:0] sum;
		high = low + range;
		sum = pos + step;
		if (step > 0 && sum > high) begin
			wrap_add = sum - range - 32'sd1;
		end else if (step < 0 && sum < low) begin
			wrap_add = sum + range + 32'sd1;
		end else begin
			wrap_add = sum;
		end
	endfunction

	// Pick one settled encoder input, zero when out of range
	function automatic logic pick(input logic [NUM_IN-1:0] pins, input logic [3:0] idx);
		pick = (32'(idx) < NUM_IN) ? pins[idx] : 1'b0;
	endfunction

	// Keep a speed limit within its allowed span
	function automatic logic [15:0] clamp_rpm(input logic [15:0] v);
		if (v < `RPM_MIN) begin
			clamp_rpm = `RPM_MIN;
		end else if (v > `RPM_MAX) begin
			clamp_rpm = `RPM_MAX;
		end else begin
			clamp_rpm = v;
		end
	endfunction

	assign pin_raw = {home_rtb, faceplate_inputs, remote_terminal_block};
	assign enc_pin = pin_ok[NUM_IN-1:0];
	assign home_fp_pin = pin_ok[NUM_IN +: NUM_CH];
	assign home_rtb_pin = pin_ok[NUM_IN + NUM_CH +: NUM_CH];

	// Three-stage synchroniser, level taken once stages two and three agree
	for (genvar p = 0; p < NUM_PINS; p++) begin : g_sync
		always_ff @(posedge mclk) begin
			if (rst) begin
				pin_s1[p] <= 1'b0;
				pin_s2[p] <= 1'b0;
				pin_s3[p] <= 1'b0;
				pin_ok[p] <= 1'b0;
			end else begin
				pin_s1[p] <= pin_raw[p];
				pin_s2[p] <= pin_s1[p];
				pin_s3[p] <= pin_s2[p];
				if (pin_s2[p] == pin_s3[p]) begin
					pin_ok[p] <= pin_s3[p];
				end
			end
		end
	end

	// Per-channel input selection and decoding
	for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
		assign phase_a[c] = pick(enc_pin, in_map[c][`MAP_A_LSB +: 4]);
		assign phase_b[c] = pick(enc_pin, in_map[c][`MAP_A_LSB +: 4] + 4'h1);
		assign marker[c] = in_map[c][`MAP_Z_EN] & pick(enc_pin, in_map[c][`MAP_Z_LSB +: 4]);
		assign home_sw[c] = ctrl[c][`CTRL_HOME_SRC] ? home_rtb_pin[c] : home_fp_pin[c];
		assign loop_position[c] = ctrl[c][`CTRL_EXT_SEL] ? ext_pos[c] : mot_pos[c];
		assign fast_stop[c] = status[`ST_OVER_POS + c] | status[`ST_OVER_NEG + c];

		quad_decoder u_quad (
			.mclk(mclk),
			.rst(rst),
			.a(phase_a[c]),
			.b(phase_b[c]),
			.step_out(qstep[c])
		);
	end

	// Bus decode
	assign req = avs_read | avs_write;
	assign avs_waitrequest = req & ~bus_ack;
	assign sel_ch = avs_address[8:6];
	assign sel_reg = avs_address[5:0];
	assign ch_hit = 32'(sel_ch) < NUM_CH;
	assign wr_ok = avs_write & bus_ack;
	assign rd_ok = avs_read & bus_ack;

	// One wait cycle, then answer
	always_ff @(posedge mclk) begin
		if (rst) begin
			bus_ack <= 1'b0;
		end else begin
			bus_ack <= req & ~bus_ack;
		end
	end

	// Read data mux
	always_comb begin
		next_rdata = 32'h00000000;
		if (avs_address == `REG_STATUS) begin
			// Include events landing this edge, else the clear loses them
			next_rdata = status | ev_set;
		end else if (avs_address == `REG_MASK) begin
			next_rdata = mask;
		end else if (ch_hit) begin
			case (sel_reg)
				`REG_CTRL: next_rdata = ctrl[sel_ch] & 32'h00000003;
				`REG_MOT_LOW: next_rdata = mot_low[sel_ch];
				`REG_MOT_RANGE: next_rdata = mot_range[sel_ch];
				`REG_EXT_LOW: next_rdata = ext_low[sel_ch];
				`REG_EXT_RANGE: next_rdata = ext_range[sel_ch];
				`REG_RPM: next_rdata = {rpm_neg[sel_ch], rpm_pos[sel_ch]};
				`REG_ACTUAL: next_rdata = loop_position[sel_ch];
				`REG_AUX: next_rdata = ctrl[sel_ch][`CTRL_EXT_SEL] ? mot_pos[sel_ch] : ext_pos[sel_ch];
				`REG_MAP: next_rdata = in_map[sel_ch] & 32'h000001ff;
				`REG_ERR: next_rdata = {24'h000000, err_code[sel_ch]};
				default: next_rdata = 32'h00000000;
			endcase
		end
	end

	// Registered read data, held at the answering edge
	always_ff @(posedge mclk) begin
		if (rst) begin
			avs_readdata <= 32'h00000000;
		end else if (avs_read & ~bus_ack) begin
			avs_readdata <= next_rdata;
		end
	end

	// Configuration writes
	always_ff @(posedge mclk) begin
		if (rst) begin
			for (int i = 0; i < NUM_CH; i++) begin
				ctrl[i] <= 32'h00000000;
				mot_low[i] <= 32'sh00000000;
				mot_range[i] <= `RST_RANGE;
				ext_low[i] <= 32'sh00000000;
				ext_range[i] <= `RST_RANGE;
				rpm_pos[i] <= `RPM_MAX;
				rpm_neg[i] <= `RPM_MAX;
				in_map[i] <= `RST_MAP;
			end
			mask <= 32'h00000000;
			home_go <= '0;
		end else begin
			home_go <= '0;
			if (wr_ok && avs_address == `REG_MASK) begin
				mask <= avs_writedata;
			end
			if (wr_ok && ch_hit) begin
				case (sel_reg)
					`REG_CTRL: begin
						ctrl[sel_ch] <= avs_writedata & 32'h00000003;
						home_go[sel_ch] <= avs_writedata[`CTRL_HOME_GO];
					end
					`REG_MOT_LOW: mot_low[sel_ch] <= avs_writedata;
					`REG_MOT_RANGE: mot_range[sel_ch] <= avs_writedata;
					`REG_EXT_LOW: ext_low[sel_ch] <= avs_writedata;
					`REG_EXT_RANGE: ext_range[sel_ch] <= avs_writedata;
					`REG_RPM: begin
						rpm_pos[sel_ch] <= clamp_rpm(avs_writedata[`RPM_POS_LSB +: 16]);
						rpm_neg[sel_ch] <= clamp_rpm(avs_writedata[`RPM_NEG_LSB +: 16]);
					end
					`REG_MAP: in_map[sel_ch] <= avs_writedata & 32'h000001ff;
					default: ;
				endcase
			end
		end
	end

	// Motor encoder position, always rotary within its own limits
	always_ff @(posedge mclk) begin
		if (rst) begin
			for (int i = 0; i < NUM_CH; i++) begin
				mot_pos[i] <= 32'sh00000000;
				speed_hold[i] <= 16'sh0000;
			end
		end else begin
			for (int i = 0; i < NUM_CH; i++) begin
				if (motor_sample[i].valid) begin
					mot_pos[i] <= wrap_add(mot_pos[i], 32'(motor_sample[i].delta),
						mot_low[i], mot_range[i]);
					speed_hold[i] <= motor_sample[i].speed;
				end
			end
		end
	end

	// External encoder position, rotary whether source or auxiliary
	always_ff @(posedge mclk) begin
		if (rst) begin
			for (int i = 0; i < NUM_CH; i++) begin
				ext_pos[i] <= 32'sh00000000;
			end
		end else begin
			for (int i = 0; i < NUM_CH; i++) begin
				if (home_done[i] && ctrl[i][`CTRL_EXT_SEL]) begin
					ext_pos[i] <= ext_low[i];
				end else if (qstep[i].step) begin
					ext_pos[i] <= wrap_add(ext_pos[i], qstep[i].up ? 32'sd1 : -32'sd1,
						ext_low[i], ext_range[i]);
				end
			end
		end
	end

	// Limiter period divider
	always_ff @(posedge mclk) begin
		if (rst) begin
			limit_cnt <= 32'h00000000;
			limit_tick <= 1'b0;
		end else begin
			limit_tick <= (limit_cnt == 32'(LIMIT_CYCLES - 1));
			limit_cnt <= (limit_cnt == 32'(LIMIT_CYCLES - 1)) ? 32'h00000000 : limit_cnt + 32'h1;
		end
	end

	// Speed limit check once per limiter period
	always_comb begin
		for (int i = 0; i < NUM_CH; i++) begin
			over_pos[i] = limit_tick && (32'(speed_hold[i]) > $signed({16'h0000, rpm_pos[i]}));
			over_neg[i] = limit_tick && (32'(speed_hold[i]) < -$signed({16'h0000, rpm_neg[i]}));
		end
	end

	// Home search: switch, then marker edge
	always_ff @(posedge mclk) begin
		if (rst) begin
			for (int i = 0; i < NUM_CH; i++) begin
				home_state[i] <= home_idle;
			end
			home_done <= '0;
			home_refused <= '0;
			marker_prev <= '0;
		end else begin
			marker_prev <= marker;
			home_done <= '0;
			home_refused <= '0;
			for (int i = 0; i < NUM_CH; i++) begin
				case (home_state[i])
					home_idle: begin
						if (home_go[i] && !in_map[i][`MAP_Z_EN]) begin
							home_refused[i] <= 1'b1;
						end else if (home_go[i]) begin
							home_state[i] <= home_wait_switch;
						end
					end
					home_wait_switch: begin
						if (home_sw[i]) begin
							home_state[i] <= home_wait_marker;
						end
					end
					home_wait_marker: begin
						if (marker[i] && !marker_prev[i]) begin
							home_done[i] <= 1'b1;
							home_state[i] <= home_idle;
						end
					end
					default: home_state[i] <= home_idle;
				endcase
			end
		end
	end

	// Gather events into status layout
	always_comb begin
		ev_set = 32'h00000000;
		for (int i = 0; i < NUM_CH; i++) begin
			ev_set[`ST_OVER_POS + i] = over_pos[i];
			ev_set[`ST_OVER_NEG + i] = over_neg[i];
			ev_set[`ST_QUAD_ERR + i] = qstep[i].err;
			ev_set[`ST_HOME_DONE + i] = home_done[i];
		end
	end

	// Sticky status, cleared by read, a new event wins over the clear
	always_ff @(posedge mclk) begin
		if (rst) begin
			status <= 32'h00000000;
		end else if (rd_ok && avs_address == `REG_STATUS) begin
			status <= ev_set;
		end else begin
			status <= status | ev_set;
		end
	end

	// Last error code per axis
	always_ff @(posedge mclk) begin
		if (rst) begin
			for (int i = 0; i < NUM_CH; i++) begin
				err_code[i] <= 8'h00;
			end
		end else begin
			for (int i = 0; i < NUM_CH; i++) begin
				if (over_pos[i]) begin
					err_code[i] <= `ERR_OVER_POS;
				end else if (over_neg[i]) begin
					err_code[i] <= `ERR_OVER_NEG;
				end else if (home_refused[i]) begin
					err_code[i] <= `ERR_HOME_NO_MARKER;
				end
			end
		end
	end

	// Level interrupt from unmasked status
	always_ff @(posedge mclk) begin
		if (rst) begin
			irq <= 1'b0;
		end else begin
			irq <= |((status | ev_set) & mask);
		end
	end

endmodule

`default_nettype wire

//--- axis_encoder_model.sv
// Behavioural motor serial encoder and quadrature encoders for the axis block.
// Assumes the bench calls these tasks from one process clocked by mclk.
`timescale 1ns/100ps
`default_nettype none

module axis_encoder_model
	import axis_feedback_pkg::*;
#(
	parameter int NUM_CH = 5,
	parameter int NUM_IN = 12
)(
	input wire logic mclk,
	output motor_sample_type motor_sample [NUM_CH],
	output logic [NUM_IN-1:0] pins
);
	// Quiet lines at time zero
	initial begin
		pins = '0;
		foreach (motor_sample[i]) motor_sample[i] = '0;
	end

	// One sample pulse; fields scrambled once the pulse ends
	task automatic smp(input int ch, input logic signed [15:0] d, input logic signed [15:0] s);
		@(posedge mclk);
		motor_sample[ch] <= '{1'b1, d, s};
		@(posedge mclk);
		motor_sample[ch] <= '{1'b0, ~d, ~s};
	endtask

	// Gray steps on pair p, A leads B going up, one bit per step
	task automatic quad(input int p, input int n, input bit up);
		repeat (n) begin
			@(posedge mclk);
			pins[p] <= up ? ~pins[p+1] : pins[p+1];
			pins[p+1] <= up ? pins[p] : ~pins[p];
			repeat (7) @(posedge mclk);
		end
	endtask

	// Marker pulse on input p
	task automatic mark(input int p);
		@(posedge mclk);
		pins[p] <= 1'b1;
		repeat (8) @(posedge mclk);
		pins[p] <= 1'b0;
	endtask
endmodule

`default_nettype wire

//--- axis_position_feedback_rollover_asserts.sv
// Checker for the axis feedback block, bound to its top module.
// Assumes axis 0 config reaches the block only over the register bus.
`timescale 1ns/100ps
`default_nettype none

module axis_position_feedback_rollover_asserts
	import axis_feedback_pkg::*;
#(
	parameter int NUM_CH = 5,
	parameter int LIMIT_CYCLES = 40000
)(
	input wire logic mclk,
	input wire logic rst,
	input wire logic [8:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic avs_waitrequest,
	input wire motor_sample_type motor_sample [NUM_CH],
	input wire logic signed [31:0] loop_position [NUM_CH],
	input wire logic [NUM_CH-1:0] fast_stop,
	input wire logic irq
);
	logic acc; // Access completes this cycle
	logic signed [31:0] low0, rng0; // Axis 0 motor limits
	logic ext0; // Axis 0 external select
	logic [31:0] rpm0; // Axis 0 speed limits
	logic signed [15:0] spd; // Latest axis 0 speed
	int cp, cn; // Cycles spent over a limit unreported

	default clocking @(posedge mclk); endclocking
	default disable iff (rst);

	assign acc = (avs_read || avs_write) && !avs_waitrequest;

	// Shadow of axis 0 configuration
	always_ff @(posedge mclk) begin
		if (rst) begin
			low0 <= '0;
			rng0 <= 32'h00000167;
			ext0 <= 1'b0;
			rpm0 <= 32'h27102710;
		end else if (avs_write && !avs_waitrequest) begin
			if (avs_address == 9'h004) low0 <= avs_writedata;
			if (avs_address == 9'h008) rng0 <= avs_writedata;
			if (avs_address == 9'h000) ext0 <= avs_writedata[0];
			if (avs_address == 9'h014) rpm0 <= avs_writedata;
		end
	end

	// Time over each limit without a fast stop
	always_ff @(posedge mclk) begin
		if (rst) begin
			spd <= '0;
			cp <= 0;
			cn <= 0;
		end else begin
			if (motor_sample[0].valid) spd <= motor_sample[0].speed;
			cp <= (spd > $signed({1'b0, rpm0[15:0]}) && !fast_stop[0]) ? cp + 1 : 0;
			cn <= (spd < -$signed({1'b0, rpm0[31:16]}) && !fast_stop[0]) ? cn + 1 : 0;
		end
	end

	// One step of rollover
	function automatic logic signed [31:0] wrap(input logic signed [31:0] s,
			input logic signed [15:0] d, input logic signed [31:0] lo,
			input logic signed [31:0] r);
		if (d > 0 && s > lo + r) return s - r - 1;
		if (d < 0 && s < lo) return s + r + 1;
		return s;
	endfunction

	property p_wait_one;
		avs_waitrequest |=> !avs_waitrequest;
	endproperty
	a_wait_one: assert property (p_wait_one) else $error("wait longer than one cycle");
	property p_wait_first;
		$rose(avs_read || avs_write) |-> avs_waitrequest;
	endproperty
	a_wait_first: assert property (p_wait_first) else $error("no wait on first cycle");
	property p_quiet;
		$fell(rst) |-> !irq && fast_stop == '0;
	endproperty
	a_quiet: assert property (p_quiet) else $error("outputs active after reset");
	property p_stop_clear;
		$fell(fast_stop[0]) |-> $past(acc && avs_read && avs_address == 9'h140);
	endproperty
	a_stop_clear: assert property (p_stop_clear) else $error("stop dropped without read");
	property p_irq_fall;
		$fell(irq) |-> $past(acc) || $past(acc, 2);
	endproperty
	a_irq_fall: assert property (p_irq_fall) else $error("irq dropped without access");
	property p_pos_limit;
		cp <= LIMIT_CYCLES + 2;
	endproperty
	a_pos_limit: assert property (p_pos_limit) else $error("positive overspeed late");
	property p_neg_limit;
		cn <= LIMIT_CYCLES + 2;
	endproperty
	a_neg_limit: assert property (p_neg_limit) else $error("negative overspeed late");
	property p_wrap;
		$past(motor_sample[0].valid) && !ext0 && !$past(acc) |-> loop_position[0] ==
			wrap($past(loop_position[0]) + $past(motor_sample[0].delta),
			$past(motor_sample[0].delta), low0, rng0);
	endproperty
	a_wrap: assert property (p_wrap) else $error("motor position wrong");
endmodule

bind axis_position_feedback_rollover axis_position_feedback_rollover_asserts #(
	.NUM_CH(NUM_CH), .LIMIT_CYCLES(LIMIT_CYCLES)) chk_u (
	.mclk(mclk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
	.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_waitrequest(avs_waitrequest),
	.motor_sample(motor_sample), .loop_position(loop_position), .fast_stop(fast_stop),
	.irq(irq));

`default_nettype wire

//--- tb.sv
// Self-checking bench for the axis feedback block.
// Assumes the encoder model drives samples and pins; limiter shortened to 20 cycles.
`timescale 1ns/100ps
`default_nettype none

module tb;
	import axis_feedback_pkg::*;
	localparam int LC = 20; // Short limiter period
	logic mclk, rst, avs_read, avs_write, avs_waitrequest, irq;
	logic [8:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, q;
	motor_sample_type motor_sample [5];
	logic [11:0] pins;
	logic [4:0] faceplate_inputs, home_rtb, fast_stop;
	logic signed [31:0] loop_position [5];
	int n_fail = 0;
	int num_checks = 0;
	int cyc = 0;

	// 40 MHz clock
	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end

	axis_position_feedback_rollover #(.LIMIT_CYCLES(LC)) dut_u (
		.mclk(mclk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .motor_sample(motor_sample),
		.remote_terminal_block(pins), .faceplate_inputs(faceplate_inputs),
		.home_rtb(home_rtb), .loop_position(loop_position), .fast_stop(fast_stop), .irq(irq));

	axis_encoder_model pm (.mclk(mclk), .motor_sample(motor_sample), .pins(pins));

	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		num_checks++;
		if (s !== e) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", nm, e, s);
		end
	endtask

	// One Avalon access, held until waitrequest is seen low
	task automatic bus(input logic w, input logic [8:0] a, input logic [31:0] d);
		@(posedge mclk);
		avs_address <= a;
		avs_write <= w;
		avs_read <= !w;
		avs_writedata <= d;
		do @(posedge mclk); while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	task automatic wr(input logic [8:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask
	task automatic rd(input logic [8:0] a, input logic [31:0] e);
		bus(1'b0, a, '0);
		chk($sformatf("reg %h", a), q, e);
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
	endtask
	task automatic wait_stop();
		for (int i = 0; i < LC + 3 && fast_stop[0] !== 1'b1; i++) @(posedge mclk);
		chk("fast_stop", fast_stop[0], 1'b1);
	endtask

	// Reset values, read-only and unmapped places
	task automatic t_reset();
		rd(9'h008, 32'h167);
		rd(9'h108, 32'h167);
		rd(9'h014, 32'h27102710);
		rd(9'h144, 32'h0);
		wr(9'h180, 32'hffffffff);
		rd(9'h180, 32'h0);
		wr(9'h018, 32'h7b);
		rd(9'h018, 32'h0);
	endtask

	// Motor rollover both ways and with a new range
	task automatic t_roll();
		pm.smp(0, 350, 0);
		pm.smp(0, 15, 0);
		@(negedge mclk);
		chk("pos", loop_position[0], 365 - 360);
		pm.smp(0, -10, 0);
		@(negedge mclk);
		chk("pos", loop_position[0], -5 + 360);
		wr(9'h008, 32'd99);
		pm.smp(0, -300, 0);
		pm.smp(0, 45, 0);
		@(negedge mclk);
		chk("pos", loop_position[0], 100 - 100);
	endtask

	// Speed limits, status, mask and interrupt
	task automatic t_speed();
		wr(9'h014, 32'h27100064);
		pm.smp(0, 0, 100);
		tick(2 * LC + 4);
		chk("no stop", fast_stop[0], 1'b0);
		wr(9'h144, 32'h1);
		pm.smp(0, 0, 101);
		wait_stop();
		rd(9'h024, 32'he5);
		tick(3);
		chk("irq", irq, 1'b1);
		pm.smp(0, 0, 0);
		bus(1'b0, 9'h140, '0);
		chk("status", q & 32'h101, 32'h1);
		tick(3);
		chk("irq", {fast_stop[0], irq}, 2'b00);
		pm.smp(0, 0, -10001);
		wait_stop();
		rd(9'h024, 32'he6);
		tick(3);
		chk("masked irq", irq, 1'b0);
		bus(1'b0, 9'h140, '0);
		chk("status", q & 32'h101, 32'h100);
		pm.smp(0, 0, 0);
		wr(9'h054, 32'h4e200005);
		rd(9'h054, 32'h2710000a);
	endtask

	// External feedback, auxiliary counts and rotary motor count
	task automatic t_ext();
		wr(9'h060, 32'h2);
		wr(9'h000, 32'h1);
		pm.quad(0, 8, 1'b1);
		tick(10);
		@(negedge mclk);
		chk("ext pos", loop_position[0], 8);
		pm.quad(0, 10, 1'b0);
		tick(10);
		@(negedge mclk);
		chk("ext pos", loop_position[0], -2 + 360);
		pm.smp(0, -1, 0);
		rd(9'h01c, -1 + 100);
		pm.quad(2, 3, 1'b0);
		tick(10);
		rd(9'h05c, -3 + 360);
	endtask

	// Homing refused without marker, then done on faceplate switch and on terminal block switch
	task automatic t_home();
		wr(9'h040, 32'h4);
		tick(1);
		rd(9'h064, 32'h30);
		wr(9'h020, 32'h140);
		wr(9'h000, 32'h5);
		faceplate_inputs <= 5'h01;
		tick(8);
		pm.mark(4);
		tick(12);
		@(negedge mclk);
		chk("home pos", loop_position[0], 0);
		bus(1'b0, 9'h140, '0);
		chk("home done", q & 32'h01000000, 32'h01000000);
		faceplate_inputs <= 5'h00;
		wr(9'h000, 32'h7);
		home_rtb <= 5'h01;
		tick(8);
		pm.mark(4);
		tick(12);
		bus(1'b0, 9'h140, '0);
		chk("rtb home", q & 32'h01000000, 32'h01000000);
		home_rtb <= 5'h00;
	endtask

	task automatic finish_test();
		if (n_fail == 0 && num_checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask

	// Cycle ceiling against hangs
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_fail++;
			finish_test();
		end
	end

	// Main sequence
	initial begin
		rst = 1'b1;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_address = '0;
		avs_writedata = '0;
		faceplate_inputs = '0;
		home_rtb = '0;
		tick(6);
		rst <= 1'b0;
		t_reset();
		t_roll();
		t_speed();
		t_ext();
		t_home();
		finish_test();
	end
endmodule

`default_nettype wire
